// file: inc/lis_pkg.sv
// Package for the LCD driver I2C slave port: codes, field positions, timing.
// Assumes a single 25 MHz system clock that samples the bus lines directly.
package lis_pkg;

    // Clock and bus timing
    localparam int CLK_PERIOD_NS   = 40;
    localparam int HS_SCL_MAX_KHZ  = 3400;
    localparam int HS_BIT_NS       = 1000000 / HS_SCL_MAX_KHZ;
    localparam int HS_BIT_CYCLES   = HS_BIT_NS / CLK_PERIOD_NS;

    // Byte framing
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_CNT_ONE  = 4'h1;
    localparam logic [3:0] BYTE_BITS    = 4'h8;

    // Master code: upper five bits fixed, lower three free
    localparam logic [4:0] MCODE_UPPER  = 5'h01;
    localparam int         MCODE_LSB    = 3;

    // Control byte fields
    localparam int CTRL_CONT_BIT = 7;
    localparam int CTRL_DC_BIT   = 6;

    // Address byte and transmit byte fields
    localparam int ADDR_RW_BIT   = 0;
    localparam int TX_MSB        = 7;

    // Display memory pointer and output byte reset value
    localparam int                     RAM_PTR_W  = 13;
    localparam logic [RAM_PTR_W-1:0]   PTR_RESET  = 13'h0000;
    localparam logic [RAM_PTR_W-1:0]   PTR_STEP   = 13'h0001;
    localparam logic [7:0]             BYTE_RESET = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RX     = 3'b001,
        ST_ACK    = 3'b010,
        ST_TX     = 3'b011,
        ST_TXACK  = 3'b100,
        ST_SKIP   = 3'b101
    } lis_state_t;

    typedef enum logic [1:0] {
        KB_ADDR = 2'b00,
        KB_CTRL = 2'b01,
        KB_DATA = 2'b10
    } lis_kind_t;

endpackage

// file: src/lis_i2c_slave.sv
// I2C slave port of the LCD driver: START/STOP, master code, address, command words.
// Assumes bus pins arrive synchronous to clk; the pad is open drain, pulled up outside.
//
// Notes on behaviour
// - Same logic serves Hs, fast and standard rates up to 3.4 MHz.
// - Data line changes only while clock is low; one bit per pulse.
// - SDA fall with SCL high is START; SDA rise with SCL high is STOP.
// - Addressed receiver acknowledges every byte on the ninth clock pulse.
// - Acknowledger holds data low through the whole acknowledge clock high.
// - Master NACKs last read byte; slave then releases data line high.
// - Hs entry is START, master code 00001XXX, then not-acknowledge.
// - Slave never acknowledges a master code byte.
// - After repeated START, matching seven-bit address is acknowledged.
// - Hs mode held across repeated STARTs, left only on STOP or reset.
// - Matching slaves acknowledge; others ignore until the next START.
// - After write address, bytes form control byte plus data byte words.
// - Cleared continuation flag: all later bytes are data until STOP/Sr.
// - Set continuation flag: one data byte, then a control byte again.
// - Data with cleared data/command flag goes to the instruction decoder.
// - Data with set data/command flag is written to display memory.
// - Memory pointer advances after every stored display byte.
// - Read transfer returns the selected status byte; no memory read.
// - Read shifts out straight after address ack until master NACKs.
// - Continuation flag is control bit 7, data/command flag is bit 6.
// - Two address LSBs come from the two address-select pads.
`timescale 1ns/10ps

module lis_i2c_slave
    import lis_pkg::*;
#(
    parameter logic [4:0] ADDR_UPPER = 5'h0F
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // Bus pins
    input  wire logic                 sclIn,
    input  wire logic                 sdaIn,
    output logic                      serialDataDrivePadOut,
    output logic                      serialDataDrivePadOe,
    // Address select pads
    input  wire logic                 addressSelectLow,
    input  wire logic                 addressSelectHigh,
    // Instruction decoder side
    input  wire logic [7:0]           statusByte,
    input  wire logic                 ptrLoad,
    input  wire logic [RAM_PTR_W-1:0] ptrLoadValue,
    output logic                      cmdValid,
    output logic [7:0]                cmdData,
    // Display memory side
    output logic                      ramValid,
    output logic [7:0]                ramData,
    output logic [RAM_PTR_W-1:0]      ramAddr,
    // Bus status
    output logic                      hsMode,
    output logic                      busBusy
);

    typedef struct packed {
        logic                 sclPrev;
        logic                 sdaPrev;
        lis_state_t           state;
        lis_kind_t            kind;
        logic [3:0]           bitCnt;
        logic [7:0]           shift;
        logic                 readDir;
        logic                 contFlag;
        logic                 dcFlag;
        logic                 nackSeen;
        logic                 sdaOe;
        logic                 sdaOut;
        logic                 hsMode;
        logic                 busy;
        logic                 cmdValid;
        logic [7:0]           cmdData;
        logic                 ramValid;
        logic [7:0]           ramData;
        logic [RAM_PTR_W-1:0] ramAddr;
        logic [RAM_PTR_W-1:0] ptr;
    } lis_reg_t;

    lis_reg_t s_q;
    lis_reg_t s_d;

    logic       sclRise;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;
    logic       byteDone;
    logic [6:0] ownAddr;

    // Lines are sampled every clock, so at 3.4 MHz a high phase spans only a few cycles
    assign sclRise   = sclIn & ~s_q.sclPrev;
    assign sclFall   = ~sclIn & s_q.sclPrev;
    assign startCond = s_q.sclPrev & sclIn & s_q.sdaPrev & ~sdaIn;
    assign stopCond  = s_q.sclPrev & sclIn & ~s_q.sdaPrev & sdaIn;
    assign byteDone  = (s_q.state == ST_RX) && sclFall && (s_q.bitCnt == BYTE_BITS);
    assign ownAddr   = {ADDR_UPPER, addressSelectHigh, addressSelectLow};

    always_comb begin
        s_d          = s_q;
        s_d.sclPrev  = sclIn;
        s_d.sdaPrev  = sdaIn;
        s_d.cmdValid = 1'b0;
        s_d.ramValid = 1'b0;
        if (startCond) begin
            // Repeated START re-arms address phase from any state; Hs kept
            s_d.state  = ST_RX;
            s_d.kind   = KB_ADDR;
            s_d.bitCnt = BIT_CNT_ZERO;
            s_d.sdaOe  = 1'b0;
            s_d.busy   = 1'b1;
        end else if (stopCond) begin
            s_d.state  = ST_IDLE;
            s_d.sdaOe  = 1'b0;
            s_d.hsMode = 1'b0;
            s_d.busy   = 1'b0;
        end else begin
            case (s_q.state)
                ST_RX: begin
                    if (sclRise && s_q.bitCnt != BYTE_BITS) begin
                        s_d.shift  = {s_q.shift[6:0], sdaIn};
                        s_d.bitCnt = s_q.bitCnt + BIT_CNT_ONE;
                    end else if (byteDone) begin
                        s_d.bitCnt = BIT_CNT_ZERO;
                        case (s_q.kind)
                            KB_ADDR: begin
                                if (s_q.shift[7:MCODE_LSB] == MCODE_UPPER) begin
                                    s_d.hsMode = 1'b1;
                                    s_d.state  = ST_SKIP;
                                end else if (s_q.shift[7:1] == ownAddr) begin
                                    s_d.sdaOe   = 1'b1;
                                    s_d.state   = ST_ACK;
                                    s_d.readDir = s_q.shift[ADDR_RW_BIT];
                                    s_d.kind    = KB_CTRL;
                                end else begin
                                    s_d.state = ST_SKIP;
                                end
                            end
                            KB_CTRL: begin
                                s_d.contFlag = s_q.shift[CTRL_CONT_BIT];
                                s_d.dcFlag   = s_q.shift[CTRL_DC_BIT];
                                s_d.kind     = KB_DATA;
                                s_d.sdaOe    = 1'b1;
                                s_d.state    = ST_ACK;
                            end
                            default: begin
                                if (s_q.dcFlag) begin
                                    s_d.ramValid = 1'b1;
                                    s_d.ramData  = s_q.shift;
                                    s_d.ramAddr  = s_q.ptr;
                                    s_d.ptr      = s_q.ptr + PTR_STEP;
                                end else begin
                                    s_d.cmdValid = 1'b1;
                                    s_d.cmdData  = s_q.shift;
                                end
                                // Stream mode stays on data until STOP or Sr
                                s_d.kind  = s_q.contFlag ? KB_CTRL : KB_DATA;
                                s_d.sdaOe = 1'b1;
                                s_d.state = ST_ACK;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    // Low held until SCL falls, covering the whole high phase
                    if (sclFall) begin
                        if (s_q.readDir) begin
                            s_d.state  = ST_TX;
                            s_d.sdaOe  = ~statusByte[TX_MSB];
                            s_d.shift  = {statusByte[6:0], 1'b0};
                            s_d.bitCnt = BIT_CNT_ONE;
                        end else begin
                            s_d.state  = ST_RX;
                            s_d.sdaOe  = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        if (s_q.bitCnt == BYTE_BITS) begin
                            s_d.sdaOe    = 1'b0;
                            s_d.nackSeen = 1'b0;
                            s_d.state    = ST_TXACK;
                        end else begin
                            s_d.sdaOe  = ~s_q.shift[TX_MSB];
                            s_d.shift  = {s_q.shift[6:0], 1'b0};
                            s_d.bitCnt = s_q.bitCnt + BIT_CNT_ONE;
                        end
                    end
                end
                ST_TXACK: begin
                    if (sclRise) begin
                        s_d.nackSeen = sdaIn;
                    end else if (sclFall) begin
                        if (s_q.nackSeen) begin
                            s_d.state = ST_SKIP;
                        end else begin
                            s_d.state  = ST_TX;
                            s_d.sdaOe  = ~statusByte[TX_MSB];
                            s_d.shift  = {statusByte[6:0], 1'b0};
                            s_d.bitCnt = BIT_CNT_ONE;
                        end
                    end
                end
                default: begin
                    s_d.sdaOe = 1'b0;
                end
            endcase
        end
        // Decoder pointer set wins over the increment in the same cycle
        if (ptrLoad) begin
            s_d.ptr = ptrLoadValue;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q          <= '0;
            s_q.sclPrev  <= 1'b1;
            s_q.sdaPrev  <= 1'b1;
            s_q.state    <= ST_IDLE;
            s_q.kind     <= KB_ADDR;
            s_q.cmdData  <= BYTE_RESET;
            s_q.ramData  <= BYTE_RESET;
            s_q.ramAddr  <= PTR_RESET;
            s_q.ptr      <= PTR_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign serialDataDrivePadOut = s_q.sdaOut;
    assign serialDataDrivePadOe  = s_q.sdaOe;
    assign cmdValid              = s_q.cmdValid;
    assign cmdData               = s_q.cmdData;
    assign ramValid              = s_q.ramValid;
    assign ramData               = s_q.ramData;
    assign ramAddr               = s_q.ramAddr;
    assign hsMode                = s_q.hsMode;
    assign busBusy               = s_q.busy;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_start_rearm: assert property (startCond |=> s_q.state == ST_RX && s_q.bitCnt == BIT_CNT_ZERO
        && s_q.kind == KB_ADDR && !serialDataDrivePadOe)
        else $error("START did not re-arm address phase");
    a_stop_leaves_hs: assert property (stopCond |=> !hsMode && !busBusy
        && s_q.state == ST_IDLE)
        else $error("STOP did not leave Hs mode");
    a_sr_keeps_hs: assert property (hsMode && startCond |=> hsMode)
        else $error("Repeated START dropped Hs mode");
    a_mcode_no_ack: assert property (byteDone && s_q.kind == KB_ADDR
        && s_q.shift[7:MCODE_LSB] == MCODE_UPPER |=> hsMode && !serialDataDrivePadOe [*2])
        else $error("Master code was acknowledged");
    a_addr_match_ack: assert property (byteDone && s_q.kind == KB_ADDR
        && s_q.shift[7:1] == ownAddr |=> serialDataDrivePadOe && s_q.state == ST_ACK)
        else $error("Matching address not acknowledged");
    a_ack_through_high: assert property (s_q.state == ST_ACK && sclRise && !startCond
        && !stopCond |=> serialDataDrivePadOe)
        else $error("Acknowledge released during clock high");
    a_change_scl_low: assert property ($changed(serialDataDrivePadOe)
        && !$past(startCond) && !$past(stopCond) |-> !$past(sclIn))
        else $error("Data line changed with clock high");
    a_skip_silent: assert property (s_q.state == ST_SKIP |-> !serialDataDrivePadOe)
        else $error("Ignoring slave drives the bus");
    a_ctrl_then_data: assert property (byteDone && s_q.kind == KB_CTRL
        |=> s_q.kind == KB_DATA && s_q.contFlag == $past(s_q.shift[CTRL_CONT_BIT]))
        else $error("Control byte not followed by data slot");
    a_word_next_kind: assert property (byteDone && s_q.kind == KB_DATA
        |=> s_q.kind == ($past(s_q.contFlag) ? KB_CTRL : KB_DATA))
        else $error("Wrong byte kind after data byte");
    a_cmd_route: assert property (byteDone && s_q.kind == KB_DATA && !s_q.dcFlag
        |=> cmdValid && !ramValid && cmdData == $past(s_q.shift))
        else $error("Command byte not routed to decoder");
    a_ram_route: assert property (byteDone && s_q.kind == KB_DATA && s_q.dcFlag
        |=> ramValid && !cmdValid && ramData == $past(s_q.shift))
        else $error("Display byte not routed to memory");
    a_ptr_advance: assert property (ramValid && !$past(ptrLoad)
        |-> s_q.ptr == ramAddr + PTR_STEP)
        else $error("Memory pointer did not advance");
    a_read_first_bit: assert property (s_q.state == ST_ACK && s_q.readDir && sclFall
        && !startCond && !stopCond
        |=> s_q.state == ST_TX && serialDataDrivePadOe == !$past(statusByte[TX_MSB]))
        else $error("Read did not start after address ack");
    a_nack_release: assert property (s_q.state == ST_TXACK && sclRise && sdaIn
        && !startCond |=> !serialDataDrivePadOe [*2])
        else $error("Slave held line after master NACK");

    c_ram_write: cover property (ramValid ##[1:300] ramValid);
    c_cmd_write: cover property (cmdValid);
    c_read_nack: cover property (s_q.state == ST_TXACK ##1 s_q.state == ST_SKIP);
    c_hs_entry: cover property ($rose(hsMode) ##[1:300] s_q.state == ST_ACK);

endmodule

// file: sim/lis_master_model.sv
// Behavioural bus master facing the slave port: open-drain data, clock only inside frames.
// Assumes the bench calls its tasks; lines move only at the falling clk edge.
`timescale 1ns/10ps

module lis_master_model (
    // Clock
    input  wire logic clk,
    // Bus lines
    input  wire logic sdaLine,
    output logic      sclOut,
    output logic      sdaOut
);
    // Clocks per bus half period; 3 is close to the fastest the port allows
    int halfCycles = 3;

    initial begin
        sclOut = 1'b1;
        sdaOut = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Serves as first start and as repeated start
    task automatic start();
        sdaOut = 1'b1;
        hold(halfCycles);
        sclOut = 1'b1;
        hold(halfCycles);
        sdaOut = 1'b0;
        hold(halfCycles);
        sclOut = 1'b0;
    endtask

    task automatic stop();
        sdaOut = 1'b0;
        hold(halfCycles);
        sclOut = 1'b1;
        hold(halfCycles);
        sdaOut = 1'b1;
        hold(halfCycles);
    endtask

    // Data set with clock low, sampled one clk into the high phase
    task automatic bitCycle(input logic b, output logic s);
        sdaOut = b;
        hold(halfCycles);
        sclOut = 1'b1;
        hold(1);
        s = sdaLine;
        hold(halfCycles - 1);
        sclOut = 1'b0;
    endtask

    task automatic wrByte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitCycle(b[i], s);
        end
        bitCycle(1'b1, s);
        acked = ~s;
    endtask

    // Released data line reads back the pull-up
    task automatic rdByte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitCycle(1'b1, s);
            b[i] = s;
        end
        bitCycle(nack, s);
    endtask
endmodule

// file: sim/tb_lcd_driver_i2c_hs_slave.sv
// Self-checking bench for the slave port: row-driven command words, then hand-written cases.
// Assumes the behavioural master model and a pulled-up open-drain data line.
`timescale 1ns/10ps

module tb_lcd_driver_i2c_hs_slave;
    import lis_pkg::*;

    localparam logic [4:0] OWN_UPPER = 5'h0F;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] data;
        logic       isRam;
    } lis_row_t;

    logic                 clk;
    logic                 rst_b;
    logic                 sclOut;
    logic                 sdaOut;
    logic                 sdaLine;
    logic                 addressSelectLow;
    logic                 addressSelectHigh;
    logic [7:0]           statusByte;
    logic                 ptrLoad;
    logic [RAM_PTR_W-1:0] ptrLoadValue;
    logic                 padOut;
    logic                 padOe;
    logic                 cmdValid;
    logic [7:0]           cmdData;
    logic                 ramValid;
    logic [7:0]           ramData;
    logic [RAM_PTR_W-1:0] ramAddr;
    logic                 hsMode;
    logic                 busBusy;
    int                   mismatches;
    int                   nChecks;
    int                   ramCnt;
    int                   cmdCnt;
    int                   expRamCnt;
    int                   expCmdCnt;
    logic [7:0]           lastRam;
    logic [7:0]           lastCmd;
    logic [RAM_PTR_W-1:0] lastAddr;
    logic [RAM_PTR_W-1:0] expPtr;
    logic                 a;
    logic [7:0]           rb;

    // Ctrl bits other than 7 and 6 are junk on purpose in the last three rows
    lis_row_t rows[5] = '{'{8'h80, 8'hA5, 1'b0}, '{8'hC0, 8'h3C, 1'b1}, '{8'hBF, 8'h00, 1'b0},
                          '{8'h3F, 8'hFF, 1'b0}, '{8'h7F, 8'h5A, 1'b1}};

    assign sdaLine = sdaOut & ~(padOe & ~padOut);

    lis_master_model u_lis_master_model (
        .clk     (clk),
        .sdaLine (sdaLine),
        .sclOut  (sclOut),
        .sdaOut  (sdaOut)
    );

    lis_i2c_slave #(.ADDR_UPPER(OWN_UPPER)) u_lis_i2c_slave (
        .clk                   (clk),
        .rst_b                 (rst_b),
        .sclIn                 (sclOut),
        .sdaIn                 (sdaLine),
        .serialDataDrivePadOut (padOut),
        .serialDataDrivePadOe  (padOe),
        .addressSelectLow      (addressSelectLow),
        .addressSelectHigh     (addressSelectHigh),
        .statusByte            (statusByte),
        .ptrLoad               (ptrLoad),
        .ptrLoadValue          (ptrLoadValue),
        .cmdValid              (cmdValid),
        .cmdData               (cmdData),
        .ramValid              (ramValid),
        .ramData               (ramData),
        .ramAddr               (ramAddr),
        .hsMode                (hsMode),
        .busBusy               (busBusy)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (ramValid === 1'b1) begin
            ramCnt++;
            lastRam = ramData;
            lastAddr = ramAddr;
        end
        if (cmdValid === 1'b1) begin
            cmdCnt++;
            lastCmd = cmdData;
        end
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic sendAddr(input logic rw);
        u_lis_master_model.start();
        u_lis_master_model.wrByte({OWN_UPPER, addressSelectHigh, addressSelectLow, rw}, a);
        chk("addrAck", 16'(a), 16'h0001);
    endtask

    task automatic wr(input logic [7:0] b);
        u_lis_master_model.wrByte(b, a);
        chk("byteAck", 16'(a), 16'h0001);
    endtask

    // Expected pointer wraps at the pointer width
    task automatic expectByte(input logic isRam, input logic [7:0] d);
        if (isRam) begin
            expRamCnt++;
            chk("ramCnt", 16'(ramCnt), 16'(expRamCnt));
            chk("ramData", 16'(lastRam), 16'(d));
            chk("ramAddr", 16'(lastAddr), 16'(expPtr));
            expPtr = expPtr + PTR_STEP;
        end else begin
            expCmdCnt++;
            chk("cmdCnt", 16'(cmdCnt), 16'(expCmdCnt));
            chk("cmdData", 16'(lastCmd), 16'(d));
        end
        chk("ramCount", 16'(ramCnt), 16'(expRamCnt));
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    initial begin
        rst_b = 1'b0;
        addressSelectLow = 1'b0;
        addressSelectHigh = 1'b1;
        statusByte = 8'hB6;
        ptrLoad = 1'b0;
        ptrLoadValue = '0;
        expPtr = PTR_RESET;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        chk("oeRst", 16'(padOe), 16'h0000);
        chk("hsRst", 16'(hsMode), 16'h0000);
        chk("busyRst", 16'(busBusy), 16'h0000);
        chk("addrRst", 16'(ramAddr), 16'h0000);
        $display("test reset done");
        foreach (rows[i]) begin
            sendAddr(1'b0);
            chk("busy", 16'(busBusy), 16'h0001);
            wr(rows[i].ctrl);
            wr(rows[i].data);
            u_lis_master_model.stop();
            expectByte(rows[i].isRam, rows[i].data);
        end
        $display("test rows done");
        u_lis_master_model.start();
        u_lis_master_model.wrByte(8'h0B, a);
        chk("mcodeAck", 16'(a), 16'h0000);
        chk("hsEntry", 16'(hsMode), 16'h0001);
        sendAddr(1'b0);
        wr(8'h40);
        for (int i = 0; i < 3; i++) begin
            wr(8'h10 + 8'(i));
            expectByte(1'b1, 8'h10 + 8'(i));
        end
        sendAddr(1'b0);
        chk("hsHeld", 16'(hsMode), 16'h0001);
        wr(8'hC0);
        wr(8'h11);
        expectByte(1'b1, 8'h11);
        wr(8'h80);
        wr(8'h22);
        expectByte(1'b0, 8'h22);
        u_lis_master_model.stop();
        chk("hsExit", 16'(hsMode), 16'h0000);
        chk("idle", 16'(busBusy), 16'h0000);
        $display("test hs words done");
        @(negedge clk);
        ptrLoad = 1'b1;
        ptrLoadValue = 13'h1FFF;
        @(negedge clk);
        ptrLoad = 1'b0;
        expPtr = 13'h1FFF;
        sendAddr(1'b0);
        wr(8'h40);
        wr(8'h77);
        expectByte(1'b1, 8'h77);
        wr(8'h88);
        expectByte(1'b1, 8'h88);
        u_lis_master_model.stop();
        $display("test pointer wrap done");
        addressSelectLow = 1'b1;
        u_lis_master_model.start();
        u_lis_master_model.wrByte({OWN_UPPER, 2'b10, 1'b0}, a);
        chk("foreignAck", 16'(a), 16'h0000);
        u_lis_master_model.wrByte(8'h40, a);
        u_lis_master_model.wrByte(8'h99, a);
        chk("ignoredAck", 16'(a), 16'h0000);
        chk("ignoredRam", 16'(ramCnt), 16'(expRamCnt));
        u_lis_master_model.stop();
        $display("test foreign address done");
        u_lis_master_model.halfCycles = 6;
        // Selection instruction value is arbitrary here
        sendAddr(1'b0);
        wr(8'h00);
        wr(8'hD1);
        expectByte(1'b0, 8'hD1);
        sendAddr(1'b1);
        u_lis_master_model.rdByte(1'b0, rb);
        // New status must stand at the fall that opens the next byte
        statusByte = 8'h49;
        chk("status1", 16'(rb), 16'h00B6);
        u_lis_master_model.rdByte(1'b1, rb);
        chk("status2", 16'(rb), 16'h0049);
        repeat (4) @(negedge clk);
        chk("released", 16'(padOe), 16'h0000);
        chk("padOut", 16'(padOut), 16'h0000);
        u_lis_master_model.stop();
        chk("cmdQuiet", 16'(cmdCnt), 16'(expCmdCnt));
        $display("test read done");
        // Reset in mid-frame, with Hs mode entered and the clock low
        u_lis_master_model.start();
        u_lis_master_model.wrByte(8'h0B, a);
        chk("hsPreRst", 16'(hsMode), 16'h0001);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        chk("hsRst2", 16'(hsMode), 16'h0000);
        chk("busyRst2", 16'(busBusy), 16'h0000);
        chk("oeRst2", 16'(padOe), 16'h0000);
        chk("addrRst2", 16'(ramAddr), 16'h0000);
        u_lis_master_model.stop();
        expPtr = PTR_RESET;
        sendAddr(1'b0);
        wr(8'hC0);
        wr(8'hE1);
        expectByte(1'b1, 8'hE1);
        u_lis_master_model.stop();
        $display("test reset mid-run done");
        wrap_up();
    end
endmodule
